// [core/ispp_pkg.sv]
// Package for the initiator packet stream port: beat carrier, formats,
// register map and field positions.
// Assumes a single 40 MHz clock domain shared by all users of the package.
package ispp_pkg;

	localparam int DATA_W = 64;
	localparam int KEEP_W = 8;
	localparam int USER_W = 32;
	localparam int APB_ADDR_W = 8;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [KEEP_W-1:0] keep;
		logic last;
		logic [USER_W-1:0] user;
	} ispp_beat_t;

	typedef enum logic {
		header_field_format,
		raw_packet_stream_format
	} ispp_format_t;

	// Beat field values
	localparam logic [KEEP_W-1:0] KEEP_ALL = 8'hFF;
	localparam logic [USER_W-1:0] RAW_USER_MASK = 32'h0000_0002;
	localparam logic [USER_W-1:0] ID8_PAD_MASK = 32'hFF00_FF00;
	localparam int CRF_BIT = 1;

	// Register offsets (byte addresses)
	localparam logic [APB_ADDR_W-1:0] CTRL_OFS = 8'h00;
	localparam logic [APB_ADDR_W-1:0] STATUS_OFS = 8'h04;
	localparam logic [APB_ADDR_W-1:0] REQ_COUNT_OFS = 8'h08;
	localparam logic [APB_ADDR_W-1:0] RESP_COUNT_OFS = 8'h0C;

	// Control fields
	localparam int CTRL_FORMAT_BIT = 0;
	localparam int CTRL_CRF_EN_BIT = 1;
	localparam int CTRL_ID8_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// Status fields: sticky errors in the low nibble, levels above
	localparam int ERR_W = 4;
	localparam int ERR_REQ_KEEP_BIT = 0;
	localparam int ERR_REQ_CRF_BIT = 1;
	localparam int ERR_REQ_ID8_BIT = 2;
	localparam int ERR_RESP_KEEP_BIT = 3;
	localparam logic [ERR_W-1:0] ERR_RESET = 4'h0;
	localparam int ST_REQ_PKT_BIT = 8;
	localparam int ST_RESP_PKT_BIT = 9;
	localparam int ST_LINK_BUSY_BIT = 10;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

endpackage : ispp_pkg

// [core/ispp_port.sv]
// Initiator packet stream port: request stream in from user logic, through
// an 8-word FIFO to the endpoint; responses from the endpoint out to user.
// Assumes one clock, synchronous active-low reset, an APB master for setup,
// and an endpoint core that speaks valid/ready beats of ispp_beat_t.
//
// Functional notes
// RULE1 - Header format: requester keeps request byte mask at 8'hFF always.
// RULE2 - Raw format: request mask all ones except on packet's last beat.
// RULE3 - Mask bit 7 qualifies data[63:56], bit 0 qualifies data[7:0].
// RULE4 - Requests arrive as 64-bit beats carrying header then payload.
// RULE5 - Requester raises last on exactly the final beat of a packet.
// RULE6 - Header format: first-beat sideband source 31:16, destination 15:0.
// RULE7 - With 8-bit IDs the upper byte of each ID field is zero.
// RULE8 - Raw format: critical flow bit zero when critical flow disabled.
// RULE9 - Sideband means something only on a packet's first beat.
// RULE10 - A beat moves only when valid and ready are both high.
// RULE11 - Responses leave on a 64-bit bus carrying header and payload.
// RULE12 - Header format: response byte mask is 8'hFF on every beat.
// RULE13 - Raw format: response mask all ones except possibly the last beat.
// RULE14 - Response marks last beat; header format puts IDs on first beat.
// RULE15 - Raw format: request sideband is 8 bits, bit 1 asks critical flow.
// RULE16 - Raw format: response sideband bit 1 echoes critical flow flag.
// RULE17 - Valid held high keeps data, mask, last, sideband stable.
`timescale 1ns/1ps

module ispp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("ispp_fifo depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW:0] next_count;
	logic push;
	logic pop;

	assign push = in_valid && in_ready; // [RULE10]
	assign pop = out_valid && out_ready;
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	// Ready is registered so the filling side never sees a combinational path
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count <= '0;
			in_ready <= 1'b1;
		end else begin
			count <= next_count;
			in_ready <= (next_count != (AW + 1)'(DEPTH));
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

endmodule : ispp_fifo

module ispp_port #(
	parameter int REQ_DEPTH = 8,
	parameter int RESP_DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// APB register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ispp_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Request stream from user logic
	input wire logic s_axis_ireq_tvalid,
	output logic s_axis_ireq_tready,
	input wire logic [63:0] s_axis_ireq_tdata,
	input wire logic [7:0] s_axis_ireq_tkeep,
	input wire logic s_axis_ireq_tlast,
	input wire logic [31:0] s_axis_ireq_tuser,
	// Response stream to user logic
	output logic m_axis_iresp_tvalid,
	input wire logic m_axis_iresp_tready,
	output logic [63:0] m_axis_iresp_tdata,
	output logic [7:0] m_axis_iresp_tkeep,
	output logic m_axis_iresp_tlast,
	output logic [31:0] m_axis_iresp_tuser,
	// Endpoint core side
	output logic link_req_valid,
	input wire logic link_req_ready,
	output ispp_pkg::ispp_beat_t link_req_beat,
	input wire logic link_resp_valid,
	output logic link_resp_ready,
	input wire ispp_pkg::ispp_beat_t link_resp_beat
);
	import ispp_pkg::*;

	if (REQ_DEPTH != 8 && REQ_DEPTH < 2) begin : g_bad_req
		$error("ispp_port request depth too small");
	end

	localparam int BW = $bits(ispp_beat_t);

	logic [2:0] ctrl;
	ispp_format_t fmt;
	logic crf_en;
	logic id8;
	logic [ERR_W-1:0] err;
	logic [ERR_W-1:0] err_set;
	logic [31:0] req_count;
	logic [31:0] resp_count;
	logic req_first;
	logic resp_first;
	logic req_take;
	ispp_beat_t req_in;
	logic rq_valid;
	logic rq_ready;
	logic [BW-1:0] rq_data;
	logic rs_valid;
	logic rs_ready;
	logic [BW-1:0] rs_data;
	ispp_beat_t rs_beat;
	ispp_beat_t resp_fmt;
	logic resp_load;
	logic apb_setup;
	logic apb_write;
	logic [31:0] rd_value;
	logic hit;

	assign fmt = ispp_format_t'(ctrl[CTRL_FORMAT_BIT]);
	assign crf_en = ctrl[CTRL_CRF_EN_BIT];
	assign id8 = ctrl[CTRL_ID8_BIT];

	// Request side
	assign req_take = s_axis_ireq_tvalid && s_axis_ireq_tready; // [RULE10]

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			req_first <= 1'b1;
		end else if (req_take) begin
			req_first <= s_axis_ireq_tlast; // [RULE5]
		end
	end

	// Byte lanes pass untouched so mask bit n keeps qualifying byte n
	always_comb begin
		req_in.data = s_axis_ireq_tdata; // [RULE3] [RULE4]
		req_in.keep = s_axis_ireq_tkeep;
		req_in.last = s_axis_ireq_tlast;
		req_in.user = '0; // [RULE9]
		if (req_first) begin
			if (fmt == header_field_format) begin
				req_in.user = s_axis_ireq_tuser; // [RULE6]
			end else begin
				req_in.user = s_axis_ireq_tuser & RAW_USER_MASK; // [RULE15]
				if (!crf_en) begin
					req_in.user[CRF_BIT] = 1'b0; // [RULE8]
				end
			end
		end
	end

	// Violations by the requester are recorded; only the critical flow bit is also cleared
	always_comb begin
		err_set = '0;
		if (req_take) begin
			if (s_axis_ireq_tkeep != KEEP_ALL &&
				(fmt == header_field_format || !s_axis_ireq_tlast)) begin
				err_set[ERR_REQ_KEEP_BIT] = 1'b1; // [RULE1] [RULE2]
			end
			if (req_first && fmt == raw_packet_stream_format && !crf_en &&
				s_axis_ireq_tuser[CRF_BIT]) begin
				err_set[ERR_REQ_CRF_BIT] = 1'b1; // [RULE8]
			end
			if (req_first && fmt == header_field_format && id8 &&
				(s_axis_ireq_tuser & ID8_PAD_MASK) != '0) begin
				err_set[ERR_REQ_ID8_BIT] = 1'b1; // [RULE7]
			end
		end
		if (resp_load && fmt == raw_packet_stream_format &&
			!rs_beat.last && rs_beat.keep != KEEP_ALL) begin
			err_set[ERR_RESP_KEEP_BIT] = 1'b1;
		end
	end

	ispp_fifo #(.WIDTH(BW), .DEPTH(REQ_DEPTH)) u_req_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(s_axis_ireq_tvalid),
		.in_ready(s_axis_ireq_tready),
		.in_data(req_in),
		.out_valid(rq_valid),
		.out_ready(rq_ready),
		.out_data(rq_data)
	);

	assign rq_ready = !link_req_valid || link_req_ready;

	// Beat is held until the endpoint takes it
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			link_req_valid <= 1'b0;
			link_req_beat <= '0;
		end else if (rq_ready) begin
			link_req_valid <= rq_valid; // [RULE17]
			if (rq_valid) begin
				link_req_beat <= ispp_beat_t'(rq_data);
			end
		end
	end

	// Response side
	ispp_fifo #(.WIDTH(BW), .DEPTH(RESP_DEPTH)) u_resp_fifo (
		.clk(clk),
		.reset_n(reset_n),
		.in_valid(link_resp_valid),
		.in_ready(link_resp_ready),
		.in_data(link_resp_beat),
		.out_valid(rs_valid),
		.out_ready(rs_ready),
		.out_data(rs_data)
	);

	assign rs_beat = ispp_beat_t'(rs_data);
	assign rs_ready = !m_axis_iresp_tvalid || m_axis_iresp_tready; // [RULE10]
	assign resp_load = rs_valid && rs_ready;

	always_comb begin
		resp_fmt = rs_beat; // [RULE11]
		if (fmt == header_field_format || !rs_beat.last) begin
			resp_fmt.keep = KEEP_ALL; // [RULE12] [RULE13]
		end
		if (!resp_first) begin
			resp_fmt.user = '0; // [RULE9]
		end else if (fmt == raw_packet_stream_format) begin
			resp_fmt.user = rs_beat.user & RAW_USER_MASK; // [RULE16]
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			resp_first <= 1'b1;
		end else if (resp_load) begin
			resp_first <= rs_beat.last; // [RULE14]
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			m_axis_iresp_tvalid <= 1'b0;
			m_axis_iresp_tdata <= '0;
			m_axis_iresp_tkeep <= '0;
			m_axis_iresp_tlast <= 1'b0;
			m_axis_iresp_tuser <= '0;
		end else if (rs_ready) begin
			m_axis_iresp_tvalid <= rs_valid; // [RULE17]
			if (rs_valid) begin
				m_axis_iresp_tdata <= resp_fmt.data;
				m_axis_iresp_tkeep <= resp_fmt.keep;
				m_axis_iresp_tlast <= resp_fmt.last; // [RULE14]
				m_axis_iresp_tuser <= resp_fmt.user; // [RULE14]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			req_count <= COUNT_RESET;
			resp_count <= COUNT_RESET;
		end else begin
			if (req_take && s_axis_ireq_tlast) begin
				req_count <= req_count + 1'b1;
			end
			if (m_axis_iresp_tvalid && m_axis_iresp_tready &&
				m_axis_iresp_tlast) begin
				resp_count <= resp_count + 1'b1;
			end
		end
	end

	// APB slave: answers in the first access cycle
	assign apb_setup = psel && !penable && !pready;
	assign apb_write = psel && penable && pready && pwrite;

	always_comb begin
		rd_value = '0;
		hit = 1'b1;
		if (paddr == CTRL_OFS) begin
			rd_value[2:0] = ctrl;
		end else if (paddr == STATUS_OFS) begin
			rd_value[ERR_W-1:0] = err;
			rd_value[ST_REQ_PKT_BIT] = !req_first;
			rd_value[ST_RESP_PKT_BIT] = !resp_first;
			rd_value[ST_LINK_BUSY_BIT] = rq_valid || link_req_valid;
		end else if (paddr == REQ_COUNT_OFS) begin
			rd_value = req_count;
		end else if (paddr == RESP_COUNT_OFS) begin
			rd_value = resp_count;
		end else begin
			hit = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= apb_setup;
			pslverr <= apb_setup && !hit;
			if (apb_setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_value;
			end
		end
	end

	// Changing format mid-packet splits the packet's treatment; software
	// should only write control while both streams are idle.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctrl <= CTRL_RESET;
		end else if (apb_write && paddr == CTRL_OFS) begin
			ctrl <= pwdata[2:0];
		end
	end

	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			err <= ERR_RESET;
		end else if (apb_write && paddr == STATUS_OFS) begin
			err <= (err & ~pwdata[ERR_W-1:0]) | err_set;
		end else begin
			err <= err | err_set;
		end
	end

endmodule : ispp_port

// [tb/ispp_monitor.sv]
// Checker for the packet stream port, on its top-level ports.
// Assumes control is only rewritten while both streams are idle.
`timescale 1ns/1ps
module ispp_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ispp_pkg::APB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Response stream
	input wire logic m_axis_iresp_tvalid,
	input wire logic m_axis_iresp_tready,
	input wire logic [63:0] m_axis_iresp_tdata,
	input wire logic [7:0] m_axis_iresp_tkeep,
	input wire logic m_axis_iresp_tlast,
	input wire logic [31:0] m_axis_iresp_tuser,
	// Core side
	input wire logic link_req_valid,
	input wire logic link_req_ready,
	input wire ispp_pkg::ispp_beat_t link_req_beat
);
	import ispp_pkg::*;
	logic [2:0] ctrl;
	logic rsp_first, req_first;
	wire raw = ctrl[CTRL_FORMAT_BIT];
	always_ff @(posedge clk) begin
		if (!reset_n)
			ctrl <= CTRL_RESET;
		else if (psel && penable && pready && pwrite && paddr == CTRL_OFS)
			ctrl <= pwdata[2:0];
	end
	// A first beat follows reset or a last beat
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rsp_first <= 1'b1;
			req_first <= 1'b1;
		end else begin
			if (m_axis_iresp_tvalid && m_axis_iresp_tready)
				rsp_first <= m_axis_iresp_tlast;
			if (link_req_valid && link_req_ready)
				req_first <= link_req_beat.last;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence rsp_wait;
		m_axis_iresp_tvalid && !m_axis_iresp_tready;
	endsequence
	sequence rsp_held;
		m_axis_iresp_tvalid && $stable({m_axis_iresp_tdata,
			m_axis_iresp_tkeep, m_axis_iresp_tlast, m_axis_iresp_tuser});
	endsequence
	a_rsp_hold: assert property (rsp_wait |=> rsp_held)
		else $error("response beat changed before acceptance");
	a_req_hold: assert property (
		link_req_valid && !link_req_ready
		|=> link_req_valid && $stable(link_req_beat))
		else $error("core request changed before acceptance");
	a_keep_hdr: assert property (
		m_axis_iresp_tvalid && !raw |-> m_axis_iresp_tkeep == KEEP_ALL)
		else $error("header response keep not all ones");
	a_keep_mid: assert property (
		m_axis_iresp_tvalid && !m_axis_iresp_tlast
		|-> m_axis_iresp_tkeep == KEEP_ALL)
		else $error("partial keep before last beat");
	a_rsp_user_later: assert property (
		m_axis_iresp_tvalid && !rsp_first |-> m_axis_iresp_tuser == '0)
		else $error("response sideband on later beat");
	a_rsp_user_raw: assert property (
		m_axis_iresp_tvalid && raw
		|-> (m_axis_iresp_tuser & ~RAW_USER_MASK) == '0)
		else $error("raw response sideband beyond flag bit");
	a_req_user_later: assert property (
		link_req_valid && !req_first |-> link_req_beat.user == '0)
		else $error("core request sideband on later beat");
	a_req_crf_gate: assert property (
		link_req_valid && raw |-> (link_req_beat.user
		& ~(ctrl[CTRL_CRF_EN_BIT] ? RAW_USER_MASK : '0)) == '0)
		else $error("raw request sideband not gated");
endmodule : ispp_monitor

// [tb/ispp_core_model.sv]
// Loopback model of the endpoint core: returns each request beat
// unchanged as a response beat, in order.
// Assumes the bench paces it through stall only.
`timescale 1ns/1ps
module ispp_core_model (
	// Clock, reset, pacing
	input wire logic clk,
	input wire logic reset_n,
	input wire logic stall,
	// Requests from the port
	input wire logic req_valid,
	output logic req_ready,
	input wire ispp_pkg::ispp_beat_t req_beat,
	// Responses to the port
	output logic resp_valid,
	input wire logic resp_ready,
	output ispp_pkg::ispp_beat_t resp_beat
);
	import ispp_pkg::*;
	ispp_beat_t q[$];
	always @(posedge clk) begin
		if (!reset_n) begin
			q.delete();
			req_ready <= 1'b0;
			resp_valid <= 1'b0;
			resp_beat <= '0;
		end else begin
			req_ready <= !stall;
			if (req_valid && req_ready)
				q.push_back(req_beat);
			if (resp_valid && !resp_ready)
				resp_valid <= 1'b1;
			else if (q.size() > 0 && !stall) begin
				resp_valid <= 1'b1;
				resp_beat <= q.pop_front();
			end else begin
				resp_valid <= 1'b0;
				// Idle bus inverts every field each cycle, last included
				resp_beat <= ~resp_beat;
			end
		end
	end
endmodule : ispp_core_model

// [tb/ispp_port_tb.sv]
// Bench for the packet stream port: user side driven here, core side
// by a loopback model, control over APB.
`timescale 1ns/1ps
module ispp_port_tb;
	import ispp_pkg::*;
	localparam int REQ = 8;
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, iu = '0, ru;
	logic pready, pslverr, ir, rv, rl, lqv, lqr, lrv, lrr;
	logic iv = 0, il = 0, rr = 0, stall = 0, rx_on = 1, slow = 0;
	logic [63:0] id = '0, rd;
	logic [7:0] ik = '0, rk;
	logic [2:0] ctrl = '0;
	ispp_beat_t lq, lr;
	ispp_beat_t got[$];
	int n_errors = 0, check_count = 0, cyc = 0;
	initial forever #12.5 clk = ~clk;
	ispp_port #(.REQ_DEPTH(REQ)) i_ispp_port (.*,
		.s_axis_ireq_tvalid(iv), .s_axis_ireq_tready(ir),
		.s_axis_ireq_tdata(id), .s_axis_ireq_tkeep(ik),
		.s_axis_ireq_tlast(il), .s_axis_ireq_tuser(iu),
		.m_axis_iresp_tvalid(rv), .m_axis_iresp_tready(rr),
		.m_axis_iresp_tdata(rd), .m_axis_iresp_tkeep(rk),
		.m_axis_iresp_tlast(rl), .m_axis_iresp_tuser(ru),
		.link_req_valid(lqv), .link_req_ready(lqr), .link_req_beat(lq),
		.link_resp_valid(lrv), .link_resp_ready(lrr), .link_resp_beat(lr));
	ispp_core_model i_ispp_core_model (.clk(clk), .reset_n(reset_n),
		.stall(stall | (slow & cyc[0])), .req_valid(lqv), .req_ready(lqr),
		.req_beat(lq), .resp_valid(lrv), .resp_ready(lrr), .resp_beat(lr));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rr <= rx_on & ~(slow & rr);
		if (rv && rr)
			got.push_back(ispp_beat_t'{rd, rk, rl, ru});
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic summarize();
		if (n_errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task automatic check(input string nm, input logic [127:0] e, g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] q, output logic e);
		int n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1;
		// Sampled at the rising edge, before the slave's own update lands
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		if (pready !== 1'b1)
			n_errors++;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : apb
	task automatic set_ctrl(input logic [2:0] c);
		logic [31:0] q;
		logic e;
		apb(1'b1, CTRL_OFS, {29'h0, c}, q, e);
		ctrl = c;
	endtask : set_ctrl
	task automatic send(input ispp_beat_t b, input int lim, output logic ok);
		int n = 0;
		iv <= 1;
		{id, ik, il, iu} <= b;
		do begin
			@(posedge clk);
			ok = ir;
			n++;
		end while (ok !== 1'b1 && n < lim);
	endtask : send
	task automatic wait_got(input int nb);
		int n = 0;
		while (got.size() < nb && n < 300) begin
			@(posedge clk);
			n++;
		end
	endtask : wait_got
	function automatic ispp_beat_t expect_beat(ispp_beat_t b, logic first);
		ispp_beat_t e = b;
		if (!ctrl[CTRL_FORMAT_BIT] || !b.last)
			e.keep = KEEP_ALL;
		if (!first)
			e.user = '0;
		else if (ctrl[CTRL_FORMAT_BIT])
			e.user = b.user & (ctrl[CTRL_CRF_EN_BIT] ? RAW_USER_MASK : '0);
		return e;
	endfunction : expect_beat
	task automatic run_pkt(input int nb, input logic [7:0] km, kl,
		input logic [31:0] u);
		ispp_beat_t b;
		ispp_beat_t ex[$];
		logic ok;
		got.delete();
		for (int i = 0; i < nb; i++) begin
			b = '{64'h0123_4567_89AB_CDEF + 64'(i), (i == nb - 1) ? kl : km,
				i == nb - 1, (i == 0) ? u : ~u};
			ex.push_back(expect_beat(b, i == 0));
			send(b, 50, ok);
		end
		iv <= 0;
		wait_got(nb);
		foreach (ex[i])
			check("response beat", 128'(ex[i]), 128'(got[i]));
	endtask : run_pkt
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		apb(1'b0, CTRL_OFS, '0, q, e);
		check("control reset", 128'h0, 128'(q));
		apb(1'b1, CTRL_OFS, 32'h0000_0005, q, e);
		apb(1'b0, CTRL_OFS, '0, q, e);
		check("control readback", 128'h5, 128'(q));
		check("control no error", 128'h0, 128'(e));
		apb(1'b0, 8'h10, '0, q, e);
		check("unmapped error", 128'h1, 128'(e));
		set_ctrl(3'h0);
	endtask : t_regs
	task automatic t_header();
		set_ctrl(3'h4);
		run_pkt(3, 8'hFF, 8'hFF, 32'h0012_0034);
		set_ctrl(3'h0);
		run_pkt(2, 8'hFF, 8'hFF, 32'hA5C3_1E2D);
	endtask : t_header
	task automatic t_raw();
		logic [31:0] q;
		logic e;
		logic [31:0] x = (32'h1 << ERR_REQ_KEEP_BIT) |
			(32'h1 << ERR_RESP_KEEP_BIT);
		set_ctrl(3'h3);
		run_pkt(2, 8'h3C, 8'h0F, 32'h0000_00FF);
		// Mid-packet partial mask is flagged on both the request and the echo
		apb(1'b0, STATUS_OFS, '0, q, e);
		check("status errors", 128'(x), 128'(q));
		apb(1'b1, STATUS_OFS, 32'h0000_000F, q, e);
		apb(1'b0, STATUS_OFS, '0, q, e);
		check("status cleared", 128'h0, 128'(q));
		run_pkt(1, 8'hFF, 8'h80, 32'h0000_0002);
		set_ctrl(3'h1);
		slow <= 1;
		run_pkt(3, 8'hFF, 8'h01, 32'h0000_0002);
		slow <= 0;
		// Two header packets and three raw packets so far
		apb(1'b0, REQ_COUNT_OFS, '0, q, e);
		check("request packets", 128'h5, 128'(q));
		apb(1'b0, RESP_COUNT_OFS, '0, q, e);
		check("response packets", 128'h5, 128'(q));
	endtask : t_raw
	task automatic t_fill();
		ispp_beat_t b;
		ispp_beat_t ex[$];
		logic ok = 1;
		int n = 0;
		set_ctrl(3'h0);
		got.delete();
		stall <= 1;
		rx_on <= 0;
		while (ok && n < 20) begin
			b = '{64'(n), KEEP_ALL, 1'b1, 32'(n)};
			ex.push_back(b);
			send(b, 20, ok);
			n++;
		end
		// Depth plus the beat held toward the core, then one refused try
		check("full depth", 128'(REQ + 2), 128'(n));
		stall <= 0;
		rx_on <= 1;
		send(b, 50, ok);
		iv <= 0;
		wait_got(n);
		foreach (ex[i])
			check("drained beat", 128'(ex[i]), 128'(got[i]));
	endtask : t_fill
	initial begin
		repeat (20) @(posedge clk);
		reset_n <= 1;
		@(posedge clk);
		t_regs();
		t_header();
		t_raw();
		t_fill();
		summarize();
	end
endmodule : ispp_port_tb
bind ispp_port ispp_monitor i_ispp_monitor (.*);
